// >>> common/rasc_pkg.sv
// Constants and carrier types for the radio auxiliary status and control
// register bank. Assumes an 8-bit register port with 10-bit addresses.
package rasc_pkg;

  // ----------------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------------
  localparam logic [9:0] ADDR_FLAG_CTRL = 10'h310;
  localparam logic [9:0] ADDR_STATUS = 10'h311;
  localparam logic [9:0] ADDR_RSSI = 10'h312;
  localparam logic [9:0] ADDR_AFC_LIMIT = 10'h315;
  localparam logic [9:0] ADDR_IR_SETUP = 10'h319;
  localparam logic [9:0] ADDR_SHUTDOWN = 10'h322;
  localparam logic [9:0] ADDR_RX_POWER = 10'h324;
  localparam logic [9:0] ADDR_TMR_CTRL = 10'h340;
  localparam logic [9:0] ADDR_RELOAD_HI = 10'h341;
  localparam logic [9:0] ADDR_RELOAD_LO = 10'h342;
  localparam logic [9:0] ADDR_IRQ_STATUS = 10'h343;
  localparam logic [9:0] ADDR_IRQ_MASK = 10'h344;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int ST_CAL_ERROR = 6;
  localparam int ST_CAL_DONE = 5;
  localparam int ST_XTAL_SETTLED = 4;
  localparam int ST_XTAL_LEVEL = 3;
  localparam int ST_COLD_START = 2;
  localparam int ST_TIMEOUT_FLAG = 1;
  localparam int ST_TIMEOUT_LIVE = 0;
  localparam int FC_CAL_ENABLE = 1;
  localparam int FC_FLAG_CLEAR = 0;
  localparam int IR_OVERWRITE = 5;
  localparam int IR_FREQ_LSB = 3;
  localparam int IR_POWER_LSB = 0;
  localparam int SD_REQUEST = 0;
  localparam int TC_TIMER_ENABLE = 0;
  localparam int TC_XTAL_ENABLE = 1;
  localparam int IRQ_TIMEOUT = 0;
  localparam int IRQ_COLD_START = 1;
  localparam int IRQ_RSSI_VALID = 2;
  localparam int IRQ_CAL_DONE = 3;

  // ----------------------------------------------------------------------
  // Reset values, masks and figures
  // ----------------------------------------------------------------------
  localparam logic [7:0] AFC_LIMIT_RESET = 8'h32;
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam logic [7:0] IR_SETUP_MASK = 8'h3F;
  localparam logic [7:0] SHUTDOWN_MASK = 8'h01;
  localparam logic [7:0] RX_POWER_MASK = 8'h1F;
  localparam logic [7:0] FLAG_CTRL_MASK = 8'h02;
  localparam logic [7:0] TMR_CTRL_MASK = 8'h03;
  localparam logic [7:0] IRQ_MASK_BITS = 8'h0F;
  localparam logic [8:0] RSSI_OFFSET_DBM = 9'h06B;
  localparam logic [4:0] IR_BASE_DIVIDE = 5'h04;

  // ----------------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [9:0] addr;
    logic [7:0] wdata;
  } rasc_bus_req_t;

  typedef struct packed {
    logic converter_stage_enable;
    logic strength_detector_enable;
    logic if_filter_enable;
    logic rx_mixer_enable;
    logic low_noise_amp_enable;
  } rasc_rx_enables_t;

  typedef struct packed {
    logic source_enable;
    logic [4:0] divide_ratio;
    logic [2:0] power_multiple;
    logic result_overwrite_enable;
  } rasc_ir_cal_t;

endpackage : rasc_pkg

// >>> verilog/rasc_regs.sv
// Auxiliary status and control registers of the radio modem configuration
// space, with a small wake-up down-counter and an event interrupt.
// Assumes all inputs are synchronous to clk and the prescaler tick is a
// one-cycle pulse.
//
// How it works
// - status bit 6 reads calibration error while calibration is enabled.
// - status bit 5 reads calibration done, zero while still running.
// - status bit 4 reads crystal settled while crystal oscillator enabled.
// - status bit 3 shows the live crystal output level, never latched.
// - status bit 2 reads one once a cold start has been recorded.
// - status bit 1 latches a timer timeout and holds after it ends.
// - status bit 0 is high only while the timer count is zero.
// - strength byte captured per packet; power is value minus 107 dBm.
// - pull-in limit resets to 50, loads half IF bandwidth on receive.
// - image source frequency field 0 disables, 1 to 3 divide by 4, 8, 16.
// - image source power 0 off, then min, twice, three and four times.
// - bit 5 of image setup enables overwriting stored calibration results.
// - a shutdown request starts shutdown only while chip select is high.
// - receive power bits are active-high enables, bit 4 the converter.
// - writing one to flag clear bit clears timeout and cold-start flags.
// - timeout occurs when enabled timer counts down to zero at tick rate.
// - entering sleep returns every config register except the interrupt mask to its reset value.
`timescale 1ns/100ps
`default_nettype none

module rasc_regs #(
  parameter int TIMER_WIDTH = 16
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire rasc_pkg::rasc_bus_req_t bus_req,
  output logic [7:0] rd_data,
  output logic irq,
  input wire logic slow_rc_cal_error,
  input wire logic slow_rc_cal_done,
  input wire logic slow_crystal_settled,
  input wire logic slow_crystal_level,
  input wire logic cold_start_event,
  input wire logic prescaler_tick,
  input wire logic packet_received,
  input wire logic [7:0] rssi_sample,
  input wire logic receive_state_entry,
  input wire logic [8:0] if_bandwidth_khz,
  input wire logic sleep_state_entry,
  input wire logic chip_select,
  output logic slow_rc_cal_enable,
  output logic slow_crystal_enable,
  output logic power_off_start,
  output logic [7:0] afc_limit,
  output logic signed [8:0] rx_power_dbm,
  output rasc_pkg::rasc_rx_enables_t rx_enables,
  output rasc_pkg::rasc_ir_cal_t ir_cal
);

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  wire logic wr = bus_req.wr;
  wire logic [9:0] addr = bus_req.addr;
  wire logic [7:0] wdata = bus_req.wdata;
  wire logic wr_flag = wr && (addr == rasc_pkg::ADDR_FLAG_CTRL);
  wire logic wr_afc = wr && (addr == rasc_pkg::ADDR_AFC_LIMIT);
  wire logic wr_ir = wr && (addr == rasc_pkg::ADDR_IR_SETUP);
  wire logic wr_sd = wr && (addr == rasc_pkg::ADDR_SHUTDOWN);
  wire logic wr_rxp = wr && (addr == rasc_pkg::ADDR_RX_POWER);
  wire logic wr_tc = wr && (addr == rasc_pkg::ADDR_TMR_CTRL);
  wire logic wr_rhi = wr && (addr == rasc_pkg::ADDR_RELOAD_HI);
  wire logic wr_rlo = wr && (addr == rasc_pkg::ADDR_RELOAD_LO);
  wire logic wr_ist = wr && (addr == rasc_pkg::ADDR_IRQ_STATUS);
  wire logic wr_imk = wr && (addr == rasc_pkg::ADDR_IRQ_MASK);

  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  logic [7:0] flag_ctrl;
  logic [7:0] ir_setup;
  logic [7:0] shutdown_request;
  logic [7:0] rx_path_power_enables;
  logic [7:0] tmr_ctrl;
  logic [7:0] reload_hi_staged;
  logic [TIMER_WIDTH-1:0] reload;
  logic [TIMER_WIDTH-1:0] count;
  logic [7:0] rx_signal_strength;
  logic cold_start_flag;
  logic timeout_latched_flag;
  logic cal_done_prev;
  logic [3:0] irq_status;
  logic [3:0] irq_mask;

  wire logic timer_enable = tmr_ctrl[rasc_pkg::TC_TIMER_ENABLE];
  wire logic flag_clear = wr_flag && wdata[rasc_pkg::FC_FLAG_CLEAR];
  wire logic count_zero = (count == '0);
  wire logic timeout_live_event = timer_enable && count_zero;
  wire logic cal_done_rise = slow_rc_cal_done && !cal_done_prev;

  // ----------------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------------
  // Sleep entry beats a same-cycle write: the state is being lost anyway.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      flag_ctrl <= rasc_pkg::CONFIG_RESET;
      ir_setup <= rasc_pkg::CONFIG_RESET;
      shutdown_request <= rasc_pkg::CONFIG_RESET;
      rx_path_power_enables <= rasc_pkg::CONFIG_RESET;
      tmr_ctrl <= rasc_pkg::CONFIG_RESET;
    end else if (sleep_state_entry) begin
      flag_ctrl <= rasc_pkg::CONFIG_RESET;
      ir_setup <= rasc_pkg::CONFIG_RESET;
      shutdown_request <= rasc_pkg::CONFIG_RESET;
      rx_path_power_enables <= rasc_pkg::CONFIG_RESET;
      tmr_ctrl <= rasc_pkg::CONFIG_RESET;
    end else begin
      if (wr_flag) begin
        flag_ctrl <= wdata & rasc_pkg::FLAG_CTRL_MASK;
      end
      if (wr_ir) begin
        ir_setup <= wdata & rasc_pkg::IR_SETUP_MASK;
      end
      if (wr_sd) begin
        shutdown_request <= wdata & rasc_pkg::SHUTDOWN_MASK;
      end
      if (wr_rxp) begin
        rx_path_power_enables <= wdata & rasc_pkg::RX_POWER_MASK;
      end
      if (wr_tc) begin
        tmr_ctrl <= wdata & rasc_pkg::TMR_CTRL_MASK;
      end
    end
  end

  // The receive-state load wins over a software write in the same cycle.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      afc_limit <= rasc_pkg::AFC_LIMIT_RESET;
    end else if (sleep_state_entry) begin
      afc_limit <= rasc_pkg::AFC_LIMIT_RESET;
    end else if (receive_state_entry) begin
      afc_limit <= if_bandwidth_khz[8:1];
    end else if (wr_afc) begin
      afc_limit <= wdata;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_signal_strength <= 8'h00;
    end else if (sleep_state_entry) begin
      rx_signal_strength <= 8'h00;
    end else if (packet_received) begin
      rx_signal_strength <= rssi_sample;
    end
  end

  // ----------------------------------------------------------------------
  // Wake-up down-counter
  // ----------------------------------------------------------------------
  // The high byte is staged so a reload only takes effect as a whole word
  // when the low byte is written.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reload_hi_staged <= 8'h00;
      reload <= '0;
    end else if (sleep_state_entry) begin
      reload_hi_staged <= 8'h00;
      reload <= '0;
    end else begin
      if (wr_rhi) begin
        reload_hi_staged <= wdata;
      end
      if (wr_rlo) begin
        reload <= TIMER_WIDTH'({reload_hi_staged, wdata});
      end
    end
  end

  logic [TIMER_WIDTH-1:0] next_count;
  always_comb begin
    next_count = count;
    if (wr_rlo) begin
      next_count = TIMER_WIDTH'({reload_hi_staged, wdata});
    end else if (timer_enable && prescaler_tick) begin
      if (count_zero) begin
        next_count = reload;
      end else begin
        next_count = count - 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  // ----------------------------------------------------------------------
  // Hardware flags: a set in the clearing cycle wins
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cold_start_flag <= 1'b0;
      timeout_latched_flag <= 1'b0;
      cal_done_prev <= 1'b0;
    end else begin
      cal_done_prev <= slow_rc_cal_done;
      if (cold_start_event) begin
        cold_start_flag <= 1'b1;
      end else if (flag_clear) begin
        cold_start_flag <= 1'b0;
      end
      if (timeout_live_event) begin
        timeout_latched_flag <= 1'b1;
      end else if (flag_clear) begin
        timeout_latched_flag <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt status and mask
  // ----------------------------------------------------------------------
  logic [3:0] irq_events;
  always_comb begin
    irq_events = 4'h0;
    irq_events[rasc_pkg::IRQ_TIMEOUT] = timeout_live_event && prescaler_tick;
    irq_events[rasc_pkg::IRQ_COLD_START] = cold_start_event;
    irq_events[rasc_pkg::IRQ_RSSI_VALID] = packet_received;
    irq_events[rasc_pkg::IRQ_CAL_DONE] = cal_done_rise;
  end

  wire logic [3:0] irq_clear = wr_ist ? wdata[3:0] : 4'h0;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_status <= 4'h0;
      irq_mask <= 4'h0;
    end else begin
      irq_status <= irq_events | (irq_status & ~irq_clear);
      if (wr_imk) begin
        irq_mask <= wdata[3:0];
      end
    end
  end

  assign irq = |(irq_status & irq_mask);

  // ----------------------------------------------------------------------
  // Status composition and read-back
  // ----------------------------------------------------------------------
  // Calibration bits and the crystal settled bit read zero while their source
  // is disabled, so software never sees a stale answer from a stopped block;
  // the crystal level bit is not gated and reads live.
  assign slow_rc_cal_enable = flag_ctrl[rasc_pkg::FC_CAL_ENABLE];
  assign slow_crystal_enable = tmr_ctrl[rasc_pkg::TC_XTAL_ENABLE];

  logic [7:0] wakeup_timer_status;
  always_comb begin
    wakeup_timer_status = 8'h00;
    wakeup_timer_status[rasc_pkg::ST_CAL_ERROR] =
      slow_rc_cal_enable && slow_rc_cal_error;
    wakeup_timer_status[rasc_pkg::ST_CAL_DONE] =
      slow_rc_cal_enable && slow_rc_cal_done;
    wakeup_timer_status[rasc_pkg::ST_XTAL_SETTLED] =
      slow_crystal_enable && slow_crystal_settled;
    wakeup_timer_status[rasc_pkg::ST_XTAL_LEVEL] = slow_crystal_level;
    wakeup_timer_status[rasc_pkg::ST_COLD_START] = cold_start_flag;
    wakeup_timer_status[rasc_pkg::ST_TIMEOUT_FLAG] =
      timeout_latched_flag;
    wakeup_timer_status[rasc_pkg::ST_TIMEOUT_LIVE] =
      timeout_live_event;
  end

  logic [7:0] next_rd_data;
  always_comb begin
    unique case (addr)
      rasc_pkg::ADDR_FLAG_CTRL: next_rd_data = flag_ctrl;
      rasc_pkg::ADDR_STATUS: next_rd_data = wakeup_timer_status;
      rasc_pkg::ADDR_RSSI: next_rd_data = rx_signal_strength;
      rasc_pkg::ADDR_AFC_LIMIT: next_rd_data = afc_limit;
      rasc_pkg::ADDR_IR_SETUP: next_rd_data = ir_setup;
      rasc_pkg::ADDR_SHUTDOWN: next_rd_data = shutdown_request;
      rasc_pkg::ADDR_RX_POWER: next_rd_data = rx_path_power_enables;
      rasc_pkg::ADDR_TMR_CTRL: next_rd_data = tmr_ctrl;
      rasc_pkg::ADDR_RELOAD_HI: next_rd_data = reload_hi_staged;
      rasc_pkg::ADDR_RELOAD_LO: next_rd_data = reload[7:0];
      rasc_pkg::ADDR_IRQ_STATUS: next_rd_data = {4'h0, irq_status};
      rasc_pkg::ADDR_IRQ_MASK: next_rd_data = {4'h0, irq_mask};
      default: next_rd_data = 8'h00;
    endcase
  end

  // Read data stands for the single cycle after the strobe, zero otherwise.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_data <= 8'h00;
    end else begin
      rd_data <= bus_req.rd ? next_rd_data : 8'h00;
    end
  end

  // ----------------------------------------------------------------------
  // Decoded outputs
  // ----------------------------------------------------------------------
  assign power_off_start =
    shutdown_request[rasc_pkg::SD_REQUEST] && chip_select;

  assign rx_power_dbm =
    $signed({1'b0, rx_signal_strength}) -
    $signed(rasc_pkg::RSSI_OFFSET_DBM);

  // Bit 4 is named for the converter but described as an amplifier enable;
  // it is routed to the converter stage.
  assign rx_enables = rasc_pkg::rasc_rx_enables_t'(
    rx_path_power_enables[4:0]);

  wire logic [1:0] ir_freq = ir_setup[rasc_pkg::IR_FREQ_LSB +: 2];
  wire logic [2:0] ir_power = ir_setup[rasc_pkg::IR_POWER_LSB +: 3];
  wire logic [3:0] ir_power_sum = {1'b0, ir_power} + 4'h1;

  assign ir_cal.source_enable = (ir_freq != 2'h0);
  assign ir_cal.divide_ratio = (ir_freq == 2'h0) ? 5'h00 :
    5'(rasc_pkg::IR_BASE_DIVIDE << (ir_freq - 2'h1));
  assign ir_cal.power_multiple = ir_power_sum[3:1];
  assign ir_cal.result_overwrite_enable =
    ir_setup[rasc_pkg::IR_OVERWRITE];

endmodule : rasc_regs

`default_nettype wire

// >>> tb/rasc_regs_checker.sv
// Concurrent checks on the ports of the auxiliary status and control bank.
// Assumes it is bound to rasc_regs, one clock, reset active high.
`timescale 1ns/100ps
`default_nettype none

module rasc_regs_checker (
  input wire logic clk,
  input wire logic sys_rst,
  input wire rasc_pkg::rasc_bus_req_t bus_req,
  input wire logic [7:0] rd_data,
  input wire logic slow_rc_cal_error,
  input wire logic slow_crystal_level,
  input wire logic cold_start_event,
  input wire logic packet_received,
  input wire logic [7:0] rssi_sample,
  input wire logic receive_state_entry,
  input wire logic [8:0] if_bandwidth_khz,
  input wire logic sleep_state_entry,
  input wire logic chip_select,
  input wire logic slow_rc_cal_enable,
  input wire logic power_off_start,
  input wire logic [7:0] afc_limit,
  input wire logic signed [8:0] rx_power_dbm,
  input wire rasc_pkg::rasc_rx_enables_t rx_enables,
  input wire rasc_pkg::rasc_ir_cal_t ir_cal
);
  // --------------------------------------------------------------------
  // Properties
  // --------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  wire logic rd_st = bus_req.rd && bus_req.addr == rasc_pkg::ADDR_STATUS;
  wire logic wr_ir = bus_req.wr && bus_req.addr == rasc_pkg::ADDR_IR_SETUP;
  wire logic wr_rx = bus_req.wr && bus_req.addr == rasc_pkg::ADDR_RX_POWER;

  chk_cal_error: assert property (
    rd_st |=> rd_data[6] == $past(slow_rc_cal_error && slow_rc_cal_enable))
    else $error("status error bit wrong");
  chk_level_live: assert property (
    rd_st |=> rd_data[3] == $past(slow_crystal_level))
    else $error("crystal level bit wrong");
  chk_cold_sticky: assert property (
    cold_start_event ##1 rd_st |=> rd_data[2])
    else $error("cold start flag not held");
  chk_rssi_offset: assert property (
    packet_received && !sleep_state_entry |=>
      rx_power_dbm == $signed({1'b0, $past(rssi_sample)}) - 9'sd107)
    else $error("signal power offset wrong");
  chk_afc_load: assert property (
    receive_state_entry && !sleep_state_entry |=>
      afc_limit == $past(if_bandwidth_khz[8:1]))
    else $error("pull-in limit not loaded");
  chk_ir_freq: assert property (
    ir_cal.source_enable == (ir_cal.divide_ratio != 5'h00) &&
      ir_cal.divide_ratio inside {5'h00, 5'h04, 5'h08, 5'h10})
    else $error("image source divider wrong");
  chk_ir_power: assert property (
    wr_ir && !sleep_state_entry |=>
      ir_cal.power_multiple == ({1'b0, $past(bus_req.wdata[2:0])} + 4'h1) >> 1
      && ir_cal.result_overwrite_enable == $past(bus_req.wdata[5]))
    else $error("image source power wrong");
  chk_shutdown_gate: assert property (
    !chip_select |-> !power_off_start)
    else $error("shutdown without chip select");
  chk_rx_enables: assert property (
    wr_rx && !sleep_state_entry |=> rx_enables == $past(bus_req.wdata[4:0]))
    else $error("receive enables wrong");
  chk_sleep_reset: assert property (
    sleep_state_entry |=> afc_limit == rasc_pkg::AFC_LIMIT_RESET &&
      rx_enables == '0 && ir_cal == '0 && !power_off_start)
    else $error("sleep did not restore");
  chk_sd_reserved: assert property (
    bus_req.rd && bus_req.addr == rasc_pkg::ADDR_SHUTDOWN |=>
      rd_data[7:1] == 7'h00)
    else $error("reserved bits not zero");
endmodule : rasc_regs_checker

`default_nettype wire

// >>> tb/rasc_regs_tb.sv
// Self-checking bench for the auxiliary status and control register bank.
// Assumes the package, the design and the checker are compiled first.
`timescale 1ns/100ps
`default_nettype none

module rasc_regs_tb;
  // --------------------------------------------------------------------
  // Stimulus, scoreboard and verdict
  // --------------------------------------------------------------------
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  rasc_pkg::rasc_bus_req_t bus_req = '0;
  logic [7:0] rd_data, rssi_sample = 8'h00, afc_limit;
  logic [8:0] if_bandwidth_khz = 9'h000;
  logic signed [8:0] rx_power_dbm;
  logic irq, slow_rc_cal_enable, slow_crystal_enable, power_off_start;
  logic slow_rc_cal_error = 0, slow_rc_cal_done = 0, cold_start_event = 0;
  logic slow_crystal_settled = 0, slow_crystal_level = 0, chip_select = 0;
  logic prescaler_tick = 0, packet_received = 0, receive_state_entry = 0;
  logic sleep_state_entry = 0;
  rasc_pkg::rasc_rx_enables_t rx_enables;
  rasc_pkg::rasc_ir_cal_t ir_cal;
  logic [17:0] exp_q [$];
  int err_count = 0;
  int n_compared = 0;

  rasc_regs #(.TIMER_WIDTH(16)) uut (.clk(clk), .sys_rst(sys_rst),
    .bus_req(bus_req), .rd_data(rd_data), .irq(irq),
    .slow_rc_cal_error(slow_rc_cal_error), .slow_rc_cal_done(slow_rc_cal_done),
    .slow_crystal_settled(slow_crystal_settled),
    .slow_crystal_level(slow_crystal_level),
    .cold_start_event(cold_start_event), .prescaler_tick(prescaler_tick),
    .packet_received(packet_received), .rssi_sample(rssi_sample),
    .receive_state_entry(receive_state_entry),
    .if_bandwidth_khz(if_bandwidth_khz),
    .sleep_state_entry(sleep_state_entry), .chip_select(chip_select),
    .slow_rc_cal_enable(slow_rc_cal_enable),
    .slow_crystal_enable(slow_crystal_enable),
    .power_off_start(power_off_start), .afc_limit(afc_limit),
    .rx_power_dbm(rx_power_dbm), .rx_enables(rx_enables), .ir_cal(ir_cal));

  initial begin
    forever #50 clk = ~clk;
  end

  task automatic check(input string name, input logic [9:0] seen,
                       input logic [9:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic wrap_up();
    $display("compared %0d mismatched %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : wrap_up

  // A gap cycle after each strobe keeps every signal to one write per step.
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    bus_req <= '0;
    @(posedge clk);
  endtask : wr

  task automatic rd(input logic [9:0] a, input logic [7:0] e);
    exp_q.push_back({a, e});
    bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk);
    bus_req <= '0;
    @(posedge clk);
  endtask : rd

  task automatic tick();
    prescaler_tick <= 1'b1;
    @(posedge clk);
    prescaler_tick <= 1'b0;
    @(posedge clk);
  endtask : tick

  initial begin : monitor
    logic [17:0] note;
    forever begin
      @(posedge clk);
      if (bus_req.rd === 1'b1) begin
        @(negedge clk);
        note = exp_q.pop_front();
        check($sformatf("read %h", note[17:8]), rd_data, note[7:0]);
      end
    end
  end

  initial begin : watchdog
    repeat (5000) @(posedge clk);
    err_count++;
    wrap_up();
  end

  initial begin : main
    logic [7:0] v;
    logic [8:0] bw;
    rasc_pkg::rasc_ir_cal_t ir_exp;
    void'($urandom(32'h4abe8f87));
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    rd(rasc_pkg::ADDR_STATUS, 8'h00);
    rd(rasc_pkg::ADDR_RSSI, 8'h00);
    rd(rasc_pkg::ADDR_AFC_LIMIT, 8'h32);
    rd(rasc_pkg::ADDR_IR_SETUP, 8'h00);
    rd(rasc_pkg::ADDR_RX_POWER, 8'h00);
    rd(10'h3FF, 8'h00);
    wr(rasc_pkg::ADDR_STATUS, 8'hFF);
    rd(rasc_pkg::ADDR_STATUS, 8'h00);
    wr(rasc_pkg::ADDR_IR_SETUP, 8'hFF);
    rd(rasc_pkg::ADDR_IR_SETUP, 8'h3F);
    repeat (8) begin
      v = 8'($urandom);
      wr(rasc_pkg::ADDR_AFC_LIMIT, v);
      rd(rasc_pkg::ADDR_AFC_LIMIT, v);
      wr(rasc_pkg::ADDR_RX_POWER, v);
      rd(rasc_pkg::ADDR_RX_POWER, v & 8'h1F);
    end
    wr(rasc_pkg::ADDR_SHUTDOWN, 8'hFF);
    rd(rasc_pkg::ADDR_SHUTDOWN, 8'h01);
    check("power_off_start", power_off_start, 10'h000);
    chip_select <= 1'b1;
    @(posedge clk);
    check("power_off_start", power_off_start, 10'h001);
    wr(rasc_pkg::ADDR_SHUTDOWN, 8'h00);
    check("power_off_start", power_off_start, 10'h000);
    for (int i = 0; i < 64; i++) begin
      wr(rasc_pkg::ADDR_IR_SETUP, 8'(i));
      ir_exp.source_enable = (i & 24) != 0;
      ir_exp.divide_ratio = (i & 24) == 0 ? 5'h00 :
        5'(4 << (((i >> 3) & 3) - 1));
      ir_exp.power_multiple = 3'(((i & 7) + 1) / 2);
      ir_exp.result_overwrite_enable = (i & 32) != 0;
      check("ir_cal", ir_cal, ir_exp);
    end
    for (int k = 0; k < 5; k++) begin
      wr(rasc_pkg::ADDR_RX_POWER, 8'(1 << k));
      check("rx_enables", rx_enables, 10'(1 << k));
    end
    v = 8'($urandom);
    rssi_sample <= v;
    packet_received <= 1'b1;
    @(posedge clk);
    packet_received <= 1'b0;
    @(posedge clk);
    check("rx_power_dbm", 10'(rx_power_dbm), 10'(v) - 10'd107);
    rd(rasc_pkg::ADDR_RSSI, v);
    check("irq", irq, 10'h000);
    wr(rasc_pkg::ADDR_IRQ_MASK, 8'h04);
    check("irq", irq, 10'h001);
    wr(rasc_pkg::ADDR_IRQ_STATUS, 8'h04);
    check("irq", irq, 10'h000);
    bw = 9'($urandom);
    if_bandwidth_khz <= bw;
    receive_state_entry <= 1'b1;
    @(posedge clk);
    receive_state_entry <= 1'b0;
    rd(rasc_pkg::ADDR_AFC_LIMIT, bw[8:1]);
    wr(rasc_pkg::ADDR_FLAG_CTRL, 8'h02);
    wr(rasc_pkg::ADDR_TMR_CTRL, 8'h02);
    check("slow_rc_cal_enable", slow_rc_cal_enable, 10'h001);
    check("slow_crystal_enable", slow_crystal_enable, 10'h001);
    {slow_rc_cal_error, slow_rc_cal_done} <= 2'b11;
    {slow_crystal_settled, slow_crystal_level} <= 2'b11;
    @(posedge clk);
    rd(rasc_pkg::ADDR_STATUS, 8'h78);
    wr(rasc_pkg::ADDR_FLAG_CTRL, 8'h00);
    wr(rasc_pkg::ADDR_TMR_CTRL, 8'h00);
    check("slow_rc_cal_enable", slow_rc_cal_enable, 10'h000);
    check("slow_crystal_enable", slow_crystal_enable, 10'h000);
    rd(rasc_pkg::ADDR_STATUS, 8'h08);
    {slow_rc_cal_error, slow_rc_cal_done} <= 2'b00;
    {slow_crystal_settled, slow_crystal_level} <= 2'b00;
    cold_start_event <= 1'b1;
    @(posedge clk);
    cold_start_event <= 1'b0;
    rd(rasc_pkg::ADDR_STATUS, 8'h04);
    wr(rasc_pkg::ADDR_RELOAD_HI, 8'h00);
    wr(rasc_pkg::ADDR_RELOAD_LO, 8'h03);
    wr(rasc_pkg::ADDR_TMR_CTRL, 8'h01);
    for (int t = 0; t < 3; t++) begin
      tick();
      rd(rasc_pkg::ADDR_STATUS, t == 2 ? 8'h07 : 8'h04);
    end
    tick();
    rd(rasc_pkg::ADDR_STATUS, 8'h06);
    rd(rasc_pkg::ADDR_IRQ_STATUS, 8'h0B);
    wr(rasc_pkg::ADDR_FLAG_CTRL, 8'h01);
    rd(rasc_pkg::ADDR_STATUS, 8'h00);
    wr(rasc_pkg::ADDR_AFC_LIMIT, 8'h55);
    sleep_state_entry <= 1'b1;
    @(posedge clk);
    sleep_state_entry <= 1'b0;
    rd(rasc_pkg::ADDR_AFC_LIMIT, 8'h32);
    rd(rasc_pkg::ADDR_RX_POWER, 8'h00);
    wr(rasc_pkg::ADDR_AFC_LIMIT, 8'h11);
    sys_rst <= 1'b1;
    @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    check("afc_limit", afc_limit, 10'h032);
    wrap_up();
  end
endmodule : rasc_regs_tb

bind rasc_regs rasc_regs_checker chk (.clk(clk), .sys_rst(sys_rst),
  .bus_req(bus_req), .rd_data(rd_data),
  .slow_rc_cal_error(slow_rc_cal_error),
  .slow_crystal_level(slow_crystal_level),
  .cold_start_event(cold_start_event), .packet_received(packet_received),
  .rssi_sample(rssi_sample), .receive_state_entry(receive_state_entry),
  .if_bandwidth_khz(if_bandwidth_khz),
  .sleep_state_entry(sleep_state_entry), .chip_select(chip_select),
  .slow_rc_cal_enable(slow_rc_cal_enable),
  .power_off_start(power_off_start), .afc_limit(afc_limit),
  .rx_power_dbm(rx_power_dbm), .rx_enables(rx_enables), .ir_cal(ir_cal));

`default_nettype wire
